// ---- edm_xmem_top.sv ----
// Purpose: External data memory interface with stretch timing, dual pointers and timebase
// Assumes: AXI4-Lite master on the system clock; pins are asynchronous to it
// Notes: One external access at a time; commands issued while busy are dropped
//
// Overview of operation
// R1: The system clock runs at the oscillator rate with no prescaler in front of it.
// R2: An instruction cycle is four system clocks rather than twelve.
// R3: The timer counts once per twelve clocks, or once per four when software selects it.
// R4: Two independent data pointers exist and software picks which one an access uses.
// R5: An external access lasts two to nine instruction cycles, set by a 3-bit stretch field.
// R6: Code 0 gives 2 cycles and a 2-clock strobe, code 1 (reset) 3 and 4, up to 9 and 28.
// R7: The 16-bit address goes out high byte on one port and low byte muxed with data.
// R8: A configuration control chooses external bus use or general-purpose pins.
// R9: Program mode is sampled only at the falling edge of reset; here it follows the strap during reset, frozen at release.
// R10: Instruction results match the standard architecture; only timing differs.
// R11: An address latch strobe marks the low address byte before the data phase.
`timescale 1ns/10ps
`default_nettype none
module edm_xmem_top
    import edm_pkg::*;
#(
    parameter int TIMER_W = 16
) (
    input wire logic aclk, // System clock, equal to oscillator
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [AXI_DATA_W-1:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte enables
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [AXI_DATA_W-1:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic [7:0] mux_addr_data_port_in, // Low address/data port, pin level
    output logic [7:0] mux_addr_data_port_out, // Low address/data port, drive value
    output logic [7:0] mux_addr_data_port_oe_n, // Low port enable, low drives
    input wire logic [7:0] high_address_port_in, // High address port, pin level
    output logic [7:0] high_address_port_out, // High address port, drive value
    output logic [7:0] high_address_port_oe_n, // High port enable, low drives
    output logic addr_latch_en, // Address latch strobe, active high
    output logic read_strobe_n, // External read strobe, active low
    output logic write_strobe_n, // External write strobe, active low
    input wire logic prog_mode_pin, // Program mode strap
    output logic program_mode, // Program mode caught at reset release
    output logic instr_tick // Instruction cycle enable
);
    // Register state
    logic [2:0] external_data_move_stretch_select;
    logic fast_timer;
    logic bus_enable;
    logic ptr_sel;
    logic [15:0] data_pointer_pair [2];
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [15:0] gpio_out;
    logic [15:0] gpio_dir;
    logic timer_clear;
    logic timer_tick;
    logic [TIMER_W-1:0] timer_count;

    // Access engine
    edm_state_e state;
    logic busy;
    logic [5:0] elapsed;
    logic [5:0] next_elapsed;
    logic next_busy;
    logic acc_write;
    logic acc_inc;
    logic acc_ptr;
    logic [15:0] acc_addr;
    logic [2:0] acc_code;
    logic start;

    // Synchronisers and reset capture
    logic [7:0] p0_meta, p0_sync, p2_meta, p2_sync;
    logic prog_meta, prog_sync;

    // Bus slave handshake
    logic wr_take, rd_take;
    logic [9:0] wr_idx, rd_idx;

    // Two flip-flop synchronisers on every pin input
    always_ff @(posedge aclk) begin
        p0_meta <= mux_addr_data_port_in;
        p0_sync <= p0_meta;
        p2_meta <= high_address_port_in;
        p2_sync <= p2_meta;
        prog_meta <= prog_mode_pin;
        prog_sync <= prog_meta;
    end

    // Strap followed only while reset is held, frozen after; hold the pin steady in reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            program_mode <= prog_sync; // R9
        end
    end

    // Byte-lane merge for 16-bit registers
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] be);
        merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
    endfunction

    function automatic logic mapped(input logic [9:0] idx);
        mapped = (idx <= IDX_TIMER) || (idx == IDX_MEM_CLK_CTRL);
    endfunction

    assign wr_idx = s_axi_awaddr[AXI_ADDR_W-1:2];
    assign rd_idx = s_axi_araddr[AXI_ADDR_W-1:2];
    // Address and data taken together; the response slot must be free
    assign wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
    assign rd_take = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
    assign start = wr_take && (wr_idx == IDX_CMD) && s_axi_wstrb[0] && s_axi_wdata[CMD_GO]
                   && !busy && bus_enable;

    // Write channel handshake and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            s_axi_awready <= wr_take;
            s_axi_wready <= wr_take;
            if (wr_take) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Software-written configuration
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            external_data_move_stretch_select <= STRETCH_RESET; // R6
            fast_timer <= 1'b0;
            {ptr_sel, bus_enable} <= CTRL_RESET;
            wdata <= 8'h00;
            gpio_out <= 16'h0000;
            gpio_dir <= 16'h0000;
            timer_clear <= 1'b0;
        end else begin
            timer_clear <= wr_take && (wr_idx == IDX_TIMER);
            if (wr_take && s_axi_wstrb[0]) begin
                unique case (wr_idx)
                    IDX_MEM_CLK_CTRL: begin
                        external_data_move_stretch_select <= s_axi_wdata[2:0]; // R5
                        fast_timer <= s_axi_wdata[MCC_FAST_TIMER]; // R3
                    end
                    IDX_CTRL: begin
                        bus_enable <= s_axi_wdata[CTRL_BUS_EN]; // R8
                        ptr_sel <= s_axi_wdata[CTRL_PTR_SEL]; // R4
                    end
                    IDX_WDATA: wdata <= s_axi_wdata[7:0];
                    default: ;
                endcase
            end
            if (wr_take && wr_idx == IDX_GPIO_OUT) begin
                gpio_out <= merge16(gpio_out, s_axi_wdata, s_axi_wstrb);
            end
            if (wr_take && wr_idx == IDX_GPIO_DIR) begin
                gpio_dir <= merge16(gpio_dir, s_axi_wdata, s_axi_wstrb);
            end
        end
    end

    // Two pointers; a finished access with increment outranks a software write to it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_pointer_pair[0] <= 16'h0000;
            data_pointer_pair[1] <= 16'h0000;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (busy && !next_busy && acc_inc && acc_ptr == 1'(i)) begin
                    data_pointer_pair[i] <= acc_addr + 16'h0001; // R4
                end else if (wr_take && wr_idx == IDX_PTR0 + 10'(i)) begin
                    data_pointer_pair[i] <= merge16(data_pointer_pair[i], s_axi_wdata,
                                                    s_axi_wstrb); // R4
                end
            end
        end
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= rd_take;
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
                unique case (rd_idx)
                    IDX_MEM_CLK_CTRL: s_axi_rdata <= 32'({fast_timer, external_data_move_stretch_select});
                    IDX_CTRL: s_axi_rdata <= 32'({ptr_sel, bus_enable});
                    IDX_PTR0: s_axi_rdata <= 32'(data_pointer_pair[0]);
                    IDX_PTR1: s_axi_rdata <= 32'(data_pointer_pair[1]);
                    IDX_WDATA: s_axi_rdata <= 32'(wdata);
                    IDX_STATUS: s_axi_rdata <= 32'({rdata, 6'h00, program_mode, busy});
                    IDX_GPIO_OUT: s_axi_rdata <= 32'(gpio_out);
                    IDX_GPIO_DIR: s_axi_rdata <= 32'(gpio_dir);
                    IDX_GPIO_IN: s_axi_rdata <= 32'({p2_sync, p0_sync});
                    IDX_TIMER: s_axi_rdata <= 32'(timer_count);
                    default: s_axi_rdata <= 32'h0000_0000;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Clock count inside an access; length fixed by the code latched at start
    always_comb begin
        next_busy = busy;
        next_elapsed = elapsed;
        if (start) begin
            next_busy = 1'b1;
            next_elapsed = ALE_AT;
        end else if (busy) begin
            if (elapsed == edm_total_clks(acc_code) - 6'h01) begin
                next_busy = 1'b0; // R5
            end else begin
                next_elapsed = elapsed + 6'h01;
            end
        end
    end

    // Access parameters frozen at start so a stretch change cannot bend a live access
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy <= 1'b0;
            elapsed <= 6'h00;
            acc_write <= 1'b0;
            acc_inc <= 1'b0;
            acc_ptr <= 1'b0;
            acc_addr <= 16'h0000;
            acc_code <= STRETCH_RESET;
        end else begin
            busy <= next_busy;
            elapsed <= next_elapsed;
            if (start) begin
                acc_write <= s_axi_wdata[CMD_WRITE];
                acc_inc <= s_axi_wdata[CMD_INC];
                acc_ptr <= ptr_sel; // R4
                acc_addr <= data_pointer_pair[ptr_sel]; // R4
                acc_code <= external_data_move_stretch_select; // R5
            end
        end
    end

    // Phase seen by the pins in the coming cycle
    always_comb begin
        if (!next_busy) begin
            state = ST_IDLE;
        end else if (next_elapsed == ALE_AT) begin
            state = ST_ALE;
        end else if (next_elapsed < STROBE_START) begin
            state = ST_SETUP;
        end else if (next_elapsed < STROBE_START
                     + edm_strobe_clks(start ? external_data_move_stretch_select : acc_code)) begin
            state = ST_STROBE;
        end else begin
            state = ST_HOLD;
        end
    end

    // Read data taken once a mid-strobe pin level has cleared the synchroniser
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata <= 8'h00;
        end else if (busy && !acc_write
                     && elapsed == STROBE_START + edm_strobe_clks(acc_code)) begin
            rdata <= p0_sync;
        end
    end

    // Pin drivers; general-purpose mode hands both ports to software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mux_addr_data_port_out <= 8'h00;
            mux_addr_data_port_oe_n <= 8'hff;
            high_address_port_out <= 8'h00;
            high_address_port_oe_n <= 8'hff;
            addr_latch_en <= 1'b0;
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
        end else if (!bus_enable) begin
            mux_addr_data_port_out <= gpio_out[7:0]; // R8
            mux_addr_data_port_oe_n <= ~gpio_dir[7:0]; // R8
            high_address_port_out <= gpio_out[15:8]; // R8
            high_address_port_oe_n <= ~gpio_dir[15:8]; // R8
            addr_latch_en <= 1'b0;
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
        end else begin
            high_address_port_oe_n <= 8'h00; // R7
            if (start) begin
                high_address_port_out <= data_pointer_pair[ptr_sel][15:8]; // R7
            end
            addr_latch_en <= (state == ST_ALE); // R11
            read_strobe_n <= !(state == ST_STROBE && !(start ? s_axi_wdata[CMD_WRITE]
                                                             : acc_write)); // R6
            write_strobe_n <= !(state == ST_STROBE && (start ? s_axi_wdata[CMD_WRITE]
                                                             : acc_write)); // R6
            unique case (state)
                ST_ALE: begin
                    mux_addr_data_port_out <= data_pointer_pair[ptr_sel][7:0]; // R7
                    mux_addr_data_port_oe_n <= 8'h00; // R7
                end
                ST_SETUP, ST_STROBE, ST_HOLD: begin
                    mux_addr_data_port_out <= wdata; // R7
                    // Released for reads so the memory can drive the shared lines
                    mux_addr_data_port_oe_n <= acc_write ? 8'h00 : 8'hff;
                end
                ST_IDLE: begin
                    mux_addr_data_port_oe_n <= 8'hff;
                end
            endcase
        end
    end

    // Timebase runs straight off the system clock with no prescaler
    edm_timebase #(
        .TIMER_W(TIMER_W)
    ) u_timebase (
        .aclk(aclk), // R1
        .aresetn(aresetn),
        .fast_rate(fast_timer), // R3
        .timer_clear(timer_clear),
        .instr_tick(instr_tick), // R2
        .timer_tick(timer_tick),
        .timer_count(timer_count)
    );
    // Instruction semantics live in the core; this block only shapes timing (R10)
endmodule // edm_xmem_top
`default_nettype wire

// ---- edm_pkg.sv ----
// Purpose: Shared constants of the external memory block
// Assumes: AXI4-Lite, 32-bit data, one clock
// Notes: Byte address is register index times four
`default_nettype none
package edm_pkg;
    // Bus geometry
    localparam int AXI_ADDR_W = 12;
    localparam int AXI_DATA_W = 32;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Register indices; byte address is index times four
    localparam logic [9:0] IDX_CTRL = 10'h000;
    localparam logic [9:0] IDX_PTR0 = 10'h001;
    localparam logic [9:0] IDX_PTR1 = 10'h002;
    localparam logic [9:0] IDX_WDATA = 10'h003;
    localparam logic [9:0] IDX_CMD = 10'h004;
    localparam logic [9:0] IDX_STATUS = 10'h005;
    localparam logic [9:0] IDX_GPIO_OUT = 10'h006;
    localparam logic [9:0] IDX_GPIO_DIR = 10'h007;
    localparam logic [9:0] IDX_GPIO_IN = 10'h008;
    localparam logic [9:0] IDX_TIMER = 10'h009;
    localparam logic [9:0] IDX_MEM_CLK_CTRL = 10'h08e;

    // Field positions
    localparam int CTRL_BUS_EN = 0;
    localparam int CTRL_PTR_SEL = 1;
    localparam int CMD_GO = 0;
    localparam int CMD_WRITE = 1;
    localparam int CMD_INC = 2;
    localparam int MCC_FAST_TIMER = 3;
    localparam int STAT_BUSY = 0;
    localparam int STAT_PROG_MODE = 1;
    localparam int STAT_RDATA_LSB = 8;

    // Reset values
    localparam logic [2:0] STRETCH_RESET = 3'h1;
    localparam logic [1:0] CTRL_RESET = 2'h1;

    // Timing in system clocks; MIN_INSTR in instruction cycles
    localparam int CLKS_PER_INSTR = 4;
    localparam int TIMER_DIV_SLOW = 12;
    localparam int TIMER_DIV_FAST = 4;
    localparam int MIN_INSTR = 2;
    localparam logic [5:0] STROBE_MIN = 6'h02;
    localparam logic [5:0] ALE_AT = 6'h00;
    localparam logic [5:0] STROBE_START = 6'h02;

    typedef enum logic [2:0] {ST_IDLE, ST_ALE, ST_SETUP, ST_STROBE, ST_HOLD} edm_state_e;

    // Strobe width for a stretch code: 2 clocks at code 0, else four per code step
    function automatic logic [5:0] edm_strobe_clks(input logic [2:0] code);
        edm_strobe_clks = (code == 3'h0) ? STROBE_MIN : {1'b0, code, 2'b00};
    endfunction

    // Whole access length in clocks: (code + 2) instruction cycles of four clocks
    function automatic logic [5:0] edm_total_clks(input logic [2:0] code);
        edm_total_clks = 6'((32'(code) + MIN_INSTR) * CLKS_PER_INSTR);
    endfunction
endpackage
`default_nettype wire

// ---- edm_timebase.sv ----
// Purpose: Instruction enable and timer with selectable rate
// Assumes: One clock at the oscillator rate
// Notes: Slower rates are one-cycle enables
`timescale 1ns/10ps
`default_nettype none
module edm_timebase
    import edm_pkg::*;
#(
    parameter int TIMER_W = 16
) (
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic fast_rate, // Timer counts every 4 clocks when high
    input wire logic timer_clear, // Clears the timer count
    output logic instr_tick, // One pulse per instruction cycle
    output logic timer_tick, // One pulse per timer increment
    output logic [TIMER_W-1:0] timer_count // Running timer value
);
    logic [1:0] instr_div;
    logic [3:0] timer_div;
    logic [3:0] timer_last;

    // Instruction cycle of four system clocks
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instr_div <= 2'h0;
            instr_tick <= 1'b0;
        end else begin
            instr_div <= instr_div + 2'h1; // R2
            instr_tick <= (instr_div == 2'(CLKS_PER_INSTR - 1)); // R2
        end
    end

    // Rate change keeps the divide count; a count at or past the new limit ends the period on the next clock
    assign timer_last = fast_rate ? 4'(TIMER_DIV_FAST - 1) : 4'(TIMER_DIV_SLOW - 1);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_div <= 4'h0;
            timer_tick <= 1'b0;
        end else if (timer_div >= timer_last) begin
            timer_div <= 4'h0; // R3
            timer_tick <= 1'b1; // R3
        end else begin
            timer_div <= timer_div + 4'h1;
            timer_tick <= 1'b0;
        end
    end

    // Timer count; clear wins over a same-cycle increment
    always_ff @(posedge aclk) begin
        if (!aresetn || timer_clear) begin
            timer_count <= '0;
        end else if (timer_tick) begin
            timer_count <= timer_count + TIMER_W'(1); // R3
        end
    end
endmodule // edm_timebase
`default_nettype wire

// ---- edm_xmem_partner.sv ----
// Purpose: External memory model on the muxed bus
// Assumes: Address taken with the latch strobe
// Notes: Released lines show the inverse of the last drive, or memory data while the read strobe is low
`timescale 1ns/10ps
`default_nettype none
module edm_xmem_partner (
    input wire logic aclk, // System clock
    input wire logic ale, // Address latch strobe
    input wire logic rd_n, // Read strobe, active low
    input wire logic wr_n, // Write strobe, active low
    input wire logic [7:0] lo_out, // Device drive on muxed port
    input wire logic [7:0] lo_oe_n, // Device enables, low drives
    input wire logic [7:0] hi_out, // High address byte
    output logic [7:0] pin // Resolved muxed port level
);
    logic [7:0] mem [65536];
    logic [15:0] addr = 16'h0000;
    // Unwritten places read as low byte xor high byte
    initial for (int i = 0; i < 65536; i++) mem[i] = 8'(i) ^ 8'(i >> 8);
    // Latch address on the strobe, store data while writing
    always @(posedge aclk) begin
        if (ale) addr <= {hi_out, lo_out};
        if (!wr_n) mem[addr] <= lo_out;
    end
    // Stale drive never reads back as valid data
    assign pin = (lo_out & ~lo_oe_n) | ((rd_n ? ~lo_out : mem[addr]) & lo_oe_n);
endmodule // edm_xmem_partner
`default_nettype wire

// ---- edm_xmem_top_asserts.sv ----
// Purpose: Port checks of the external memory block
// Assumes: One clock, reset low
// Notes: Bound onto the top
`timescale 1ns/10ps
`default_nettype none
module edm_xmem_top_asserts (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset, low
    input wire logic s_axi_awvalid, // AW valid
    input wire logic s_axi_wvalid, // W valid
    input wire logic s_axi_awready, // AW ready
    input wire logic s_axi_bvalid, // B valid
    input wire logic s_axi_bready, // B ready
    input wire logic s_axi_arvalid, // AR valid
    input wire logic s_axi_arready, // AR ready
    input wire logic s_axi_rvalid, // R valid
    input wire logic [7:0] mux_addr_data_port_oe_n, // Muxed port enables
    input wire logic addr_latch_en, // Latch strobe
    input wire logic read_strobe_n, // Read strobe
    input wire logic write_strobe_n, // Write strobe
    input wire logic instr_tick // Instruction enable
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Instruction cycle and bus timing
    a_instr_tick_period: assert property (instr_tick |=> !instr_tick [*3] ##1 instr_tick)
        else $error("instruction tick spacing wrong");
    a_ale_one_clock: assert property (addr_latch_en |=> !addr_latch_en)
        else $error("latch strobe longer than one clock");
    a_ale_drives_low: assert property (addr_latch_en |-> mux_addr_data_port_oe_n == 8'h00)
        else $error("low address not driven with latch strobe");
    a_ale_then_strobe: assert property (addr_latch_en |-> ##2 !(read_strobe_n && write_strobe_n))
        else $error("strobe not two clocks after latch");
    a_strobe_min_width: assert property ($fell(read_strobe_n) |=> !read_strobe_n)
        else $error("read strobe too short");
    a_read_releases_port: assert property (!read_strobe_n |-> mux_addr_data_port_oe_n == 8'hff)
        else $error("port driven during read");
    a_strobes_exclusive: assert property (!(!read_strobe_n && !write_strobe_n))
        else $error("both strobes low");
    a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
        && !s_axi_awready |=> s_axi_awready && s_axi_bvalid)
        else $error("write not answered");
    a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready
        |=> s_axi_arready && s_axi_rvalid)
        else $error("read not answered");
    a_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    c_read_access: cover property ($fell(read_strobe_n));
    c_write_access: cover property ($fell(write_strobe_n));
    c_latch: cover property (addr_latch_en);
endmodule // edm_xmem_top_asserts
bind edm_xmem_top edm_xmem_top_asserts edm_xmem_top_asserts_inst (.*);
`default_nettype wire

// ---- ext_data_memory_stretch_timing_tb.sv ----
// Purpose: Test of stretch timing, pointers, ports and timer
// Assumes: AXI4-Lite master tasks, memory partner model
// Notes: Every wait is bounded; all but the strobe-width wait end the run on expiry
`timescale 1ns/10ps
`default_nettype none
module ext_data_memory_stretch_timing_tb import edm_pkg::*;;
    logic aclk = 0, aresetn = 0, prog_mode_pin = 1;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, addr_latch_en, read_strobe_n, write_strobe_n, program_mode, instr_tick;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, t0, t1;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] mux_addr_data_port_in, mux_addr_data_port_out, mux_addr_data_port_oe_n;
    logic [7:0] high_address_port_in, high_address_port_out, high_address_port_oe_n;
    int errors = 0, cmp_count = 0, cyc = 0, s;
    edm_xmem_top edm_xmem_top_inst (.*);
    edm_xmem_partner edm_xmem_partner_inst (.aclk(aclk), .ale(addr_latch_en),
        .rd_n(read_strobe_n), .wr_n(write_strobe_n), .lo_out(mux_addr_data_port_out),
        .lo_oe_n(mux_addr_data_port_oe_n), .hi_out(high_address_port_out),
        .pin(mux_addr_data_port_in));
    // Released high port bits show a fixed pattern
    assign high_address_port_in = (high_address_port_out & ~high_address_port_oe_n)
        | (8'hc3 & high_address_port_oe_n);
    initial forever #2.5 aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;
    task automatic give_verdict;
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tmo(input int n);
        if (n >= 99) begin
            errors++;
            give_verdict;
        end
    endtask
    // Write cycle: address and data together, response awaited
    task automatic wr(input logic [9:0] a, input logic [31:0] v);
        int n = 0;
        s_axi_awaddr <= {a, 2'b00};
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin @(posedge aclk); n++; end while (s_axi_awready !== 1'b1 && n < 99);
        s_axi_awvalid <= 0;
        s_axi_wvalid <= 0;
        while (s_axi_bvalid !== 1'b1 && n < 99) begin @(posedge aclk); n++; end
        tmo(n);
        chk(s_axi_bresp, RESP_OKAY);
        s_axi_bready <= 0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [9:0] a, output logic [31:0] v,
        input logic [1:0] er = RESP_OKAY);
        int n = 0;
        s_axi_araddr <= {a, 2'b00};
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin @(posedge aclk); n++; end while (s_axi_arready !== 1'b1 && n < 99);
        s_axi_arvalid <= 0;
        while (s_axi_rvalid !== 1'b1 && n < 99) begin @(posedge aclk); n++; end
        tmo(n);
        v = s_axi_rdata;
        chk(s_axi_rresp, er);
        s_axi_rready <= 0;
        @(posedge aclk);
    endtask
    // Start an access, measure strobe width, then poll until idle
    task automatic go(input logic [2:0] c, input int w, output logic [31:0] st);
        int n = 0, k = 0;
        wr(IDX_CMD, {29'h0, c});
        while ((read_strobe_n & write_strobe_n) === 1'b1 && n < 99) begin
            @(posedge aclk);
            n++;
        end
        while ((read_strobe_n & write_strobe_n) === 1'b0 && k < 99) begin
            @(posedge aclk);
            k++;
        end
        chk(k, w);
        do rd(IDX_STATUS, st); while (st[0] !== 1'b0 && ++n < 99);
        tmo(n);
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rd(IDX_MEM_CLK_CTRL, d);
        chk(d, 32'h0000_0001);
        prog_mode_pin <= 0;
        repeat (5) @(posedge aclk);
        rd(IDX_STATUS, d);
        chk(d[1:0], 2'b10);
        rd(10'h0ff, d, RESP_SLVERR);
        chk(d, 32'h0000_0000);
        for (int c = 0; c < 8; c++) begin
            s = c ? 4 * c : 2;
            wr(IDX_MEM_CLK_CTRL, c);
            wr(IDX_PTR0, 32'h0000_1200 + c);
            wr(IDX_WDATA, 32'h0000_00a0 + c);
            go(3'b011, s, d);
            go(3'b001, s, d);
            chk(d[15:8], 32'h0000_00a0 + c);
        end
        wr(IDX_CTRL, 32'h0000_0003);
        wr(IDX_PTR1, 32'h0000_34ff);
        go(3'b101, 28, d);
        chk(d[15:8], 32'h0000_00cb);
        rd(IDX_PTR1, d);
        chk(d, 32'h0000_3500);
        rd(IDX_PTR0, d);
        chk(d, 32'h0000_1207);
        chk({high_address_port_oe_n, high_address_port_out}, 32'h0000_0034);
        wr(IDX_CTRL, 32'h0000_0000);
        wr(IDX_GPIO_DIR, 32'h0000_00ff);
        wr(IDX_GPIO_OUT, 32'h0000_0055);
        wr(IDX_CMD, 32'h0000_0001);
        rd(IDX_STATUS, d);
        chk(d[0], 1'b0);
        chk({mux_addr_data_port_oe_n, mux_addr_data_port_out, high_address_port_oe_n},
            32'h0000_55ff);
        for (int f = 0; f < 2; f++) begin
            wr(IDX_MEM_CLK_CTRL, 32'h0000_0001 + 8 * f);
            s = cyc;
            rd(IDX_TIMER, t0);
            while (cyc < s + 120) @(posedge aclk);
            rd(IDX_TIMER, t1);
            chk(t1 - t0, f ? 30 : 10);
        end
        give_verdict;
    end
endmodule // ext_data_memory_stretch_timing_tb
`default_nettype wire
